// [rtl/pause_link_pkg.sv]
// Shared constants for the serial pause link
package pause_link_pkg;
   localparam int unsigned WORD_W = 8;
   localparam int unsigned BIT_CNT_W = 3;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 3'h0;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
   localparam logic [WORD_W-1:0] WORD_RST = 8'h00;
   // Master divider: half period of the serial clock in system cycles
   localparam int unsigned SCK_HALF_NS = 80;
   localparam int unsigned SYS_CLK_NS = 20;
   localparam int unsigned SCK_HALF_CYC = SCK_HALF_NS / SYS_CLK_NS;
   localparam int unsigned DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
   localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
   // Two-entry buffer depth
   localparam int unsigned BUF_DEPTH = 2;
endpackage : pause_link_pkg

// [rtl/pause_link_if.sv]
// Serial link wires between the bus master and the paused memory port
`timescale 1ns/1ps
interface pause_link_if;
   logic sck;
   logic cs_n;
   logic hold_n;
   logic mosi;
   logic miso_o;
   logic miso_oe_n;
   logic miso;
   // Resolved wire: the device drives only with its enable low; pulled low otherwise
   assign miso = (!miso_oe_n) ? miso_o : 1'b0;
   modport master (output sck, output cs_n, output hold_n, output mosi, input miso);
   modport device (input sck, input cs_n, input hold_n, input mosi, output miso_o, output miso_oe_n);
endinterface : pause_link_if

// [rtl/pause_device.sv]
// Device end: serial shift port with pause handling
`timescale 1ns/1ps
module pause_device
   import pause_link_pkg::*;
(
   // System
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Link
   pause_link_if.device link,
   // Received words
   output logic [WORD_W-1:0] o_rx_data,
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   // Words to send
   input wire logic [WORD_W-1:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   // Status
   output logic o_paused,
   output logic o_selected
);
   // Synchronisers for all pins
   logic [1:0] sck_s_q, cs_s_q, hold_s_q, mosi_s_q;
   logic sck_prev_q;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sck_s_q <= 2'h0;
         cs_s_q <= 2'h3;
         hold_s_q <= 2'h3;
         mosi_s_q <= 2'h0;
         sck_prev_q <= 1'b0;
      end else begin
         sck_s_q <= {sck_s_q[0], link.sck};
         cs_s_q <= {cs_s_q[0], link.cs_n};
         hold_s_q <= {hold_s_q[0], link.hold_n};
         mosi_s_q <= {mosi_s_q[0], link.mosi};
         sck_prev_q <= sck_s_q[1];
      end
   end

   wire sck_s = sck_s_q[1];
   wire sel = !cs_s_q[1];
   wire hold_low = !hold_s_q[1];
   wire sck_rise = sck_s && !sck_prev_q;
   wire sck_fall = !sck_s && sck_prev_q;

   logic paused_q, paused_d;
   logic begun_q;
   logic [BIT_CNT_W-1:0] bit_cnt_q;
   logic [WORD_W-1:0] sh_in_q, sh_out_q;
   // Pause enters when clock low, or at the next falling edge if clock high
   wire enter = sel && begun_q && hold_low && (!sck_s || sck_fall);
   // Leaving needs the clock low; release while high keeps pause
   wire leave = !hold_low && !sck_s;
   always_comb begin
      paused_d = paused_q;
      if (!sel) begin
         paused_d = 1'b0;
      end else if (!paused_q && enter) begin
         paused_d = 1'b1;
      end else if (paused_q && leave) begin
         paused_d = 1'b0;
      end
   end
   wire active = sel && !paused_q && !paused_d;
   wire shift_in = active && sck_rise;
   wire shift_out = active && sck_fall;
   wire word_done = shift_in && (bit_cnt_q == BIT_CNT_LAST);

   // Two-entry receive buffer; a word that completes while the buffer is full is dropped
   logic [WORD_W-1:0] buf_q [BUF_DEPTH];
   logic [1:0] cnt_q;
   logic rd_q, wr_q;
   wire buf_push = word_done && (cnt_q != 2'h2);
   wire buf_pop = o_rx_valid && i_rx_ready;

   // Shift state is kept unchanged while paused; deselect clears the bit count and output shifter, not the input shifter
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         paused_q <= 1'b0;
         begun_q <= 1'b0;
         bit_cnt_q <= BIT_CNT_RST;
         sh_in_q <= WORD_RST;
         sh_out_q <= WORD_RST;
      end else begin
         paused_q <= paused_d;
         if (!sel) begin
            begun_q <= 1'b0;
            bit_cnt_q <= BIT_CNT_RST;
         end else if (shift_in) begin
            begun_q <= 1'b1;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            sh_in_q <= {sh_in_q[WORD_W-2:0], mosi_s_q[1]};
         end
         if (!sel) begin
            sh_out_q <= WORD_RST;
         end else if (shift_out && bit_cnt_q == BIT_CNT_RST) begin
            sh_out_q <= i_tx_valid ? i_tx_data : WORD_RST;
         end else if (shift_out) begin
            sh_out_q <= {sh_out_q[WORD_W-2:0], 1'b0};
         end
      end
   end

   // Buffer storage and pointers
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= 2'h0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         buf_q[0] <= WORD_RST;
         buf_q[1] <= WORD_RST;
      end else begin
         if (buf_push) begin
            buf_q[wr_q] <= {sh_in_q[WORD_W-2:0], mosi_s_q[1]};
            wr_q <= !wr_q;
         end
         if (buf_pop) begin
            rd_q <= !rd_q;
         end
         cnt_q <= cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // Registered outputs
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rx_data <= WORD_RST;
         o_rx_valid <= 1'b0;
         o_tx_ready <= 1'b0;
         o_paused <= 1'b0;
         o_selected <= 1'b0;
         link.miso_o <= 1'b0;
         link.miso_oe_n <= 1'b1;
      end else begin
         o_rx_data <= buf_q[buf_pop ? !rd_q : rd_q];
         // Valid follows the stored count, so the data register already holds the written word
         o_rx_valid <= (cnt_q - {1'b0, buf_pop}) != 2'h0;
         o_tx_ready <= shift_out && bit_cnt_q == BIT_CNT_RST;
         o_paused <= paused_d;
         o_selected <= sel;
         link.miso_o <= sh_out_q[WORD_W-1];
         // Float when deselected, paused or pause pin low
         link.miso_oe_n <= !sel || paused_d || hold_low;
      end
   end
endmodule // pause_device

// [rtl/pause_master.sv]
// Master end: drives clock, select and pause, shifts bytes
`timescale 1ns/1ps
module pause_master
   import pause_link_pkg::*;
(
   // System
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Link
   pause_link_if.master link,
   // User commands
   input wire logic i_select,
   input wire logic i_pause,
   input wire logic [WORD_W-1:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic [WORD_W-1:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_paused
);
   typedef enum logic [1:0] {M_IDLE, M_RUN, M_PAUSE} mstate_t;
   mstate_t st_q;
   logic [DIV_W-1:0] div_q;
   logic [BIT_CNT_W-1:0] bit_q;
   logic [WORD_W-1:0] sh_q, rx_q;
   logic [1:0] miso_s_q;
   wire tick = div_q == DIV_LAST;
   // Pause and release only change while our clock is low
   wire clk_low = !link.sck;
   wire load = st_q == M_RUN && tick && clk_low && bit_q == BIT_CNT_RST && !o_tx_ready;

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= M_IDLE;
         div_q <= DIV_RST;
         bit_q <= BIT_CNT_RST;
         sh_q <= WORD_RST;
         rx_q <= WORD_RST;
         miso_s_q <= 2'h0;
         link.sck <= 1'b0;
         link.cs_n <= 1'b1;
         link.hold_n <= 1'b1;
         link.mosi <= 1'b0;
         o_tx_ready <= 1'b0;
         o_rx_data <= WORD_RST;
         o_rx_valid <= 1'b0;
         o_paused <= 1'b0;
      end else begin
         miso_s_q <= {miso_s_q[0], link.miso};
         div_q <= tick ? DIV_RST : div_q + 4'h1;
         o_tx_ready <= 1'b0;
         o_rx_valid <= 1'b0;
         case (st_q)
            M_IDLE: begin
               link.sck <= 1'b0;
               if (i_select && i_tx_valid && tick) begin
                  link.cs_n <= 1'b0;
                  sh_q <= i_tx_data;
                  link.mosi <= i_tx_data[WORD_W-1];
                  o_tx_ready <= 1'b1;
                  bit_q <= BIT_CNT_RST;
                  st_q <= M_RUN;
               end
            end
            M_RUN: begin
               if (!i_select && clk_low && tick && bit_q == BIT_CNT_RST) begin
                  link.cs_n <= 1'b1;
                  st_q <= M_IDLE;
               end else if (i_pause && clk_low && tick) begin
                  link.hold_n <= 1'b0;
                  st_q <= M_PAUSE;
               end else if (tick && clk_low && (bit_q != BIT_CNT_RST || i_tx_valid || load)) begin
                  link.sck <= 1'b1;
               end else if (tick && !clk_low) begin
                  // Sample at the end of the high phase: the returned bit needs two synchronisers each way
                  link.sck <= 1'b0;
                  bit_q <= bit_q + 3'h1;
                  rx_q <= {rx_q[WORD_W-2:0], miso_s_q[1]};
                  if (bit_q == BIT_CNT_LAST) begin
                     o_rx_data <= {rx_q[WORD_W-2:0], miso_s_q[1]};
                     o_rx_valid <= 1'b1;
                     if (i_tx_valid) begin
                        sh_q <= i_tx_data;
                        link.mosi <= i_tx_data[WORD_W-1];
                        o_tx_ready <= 1'b1;
                     end
                  end else begin
                     sh_q <= {sh_q[WORD_W-2:0], 1'b0};
                     link.mosi <= sh_q[WORD_W-2];
                  end
               end
            end
            M_PAUSE: begin
               // Release with clock still low; select stays low throughout
               if (!i_pause && tick) begin
                  link.hold_n <= 1'b1;
                  st_q <= M_RUN;
               end
            end
            default: st_q <= M_IDLE;
         endcase
         o_paused <= st_q == M_PAUSE;
      end
   end
endmodule // pause_master

// [testbench/pause_link_monitor.sv]
// Wire-level checks for the serial pause link between master and device
`timescale 1ns/1ps
module pause_link_monitor (
   // System
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Link wires
   input wire logic sck,
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   input wire logic miso
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Four cycles give the device's synchroniser time to see the level
   sequence s_paused;
      (!hold_n)[*4];
   endsequence
   sequence s_desel;
      cs_n[*4];
   endsequence
   // Device side
   chk_pause_floats_out: assert property (s_paused |-> miso_oe_n && miso == 1'b0)
      else $error("output driven while paused");
   chk_pause_quiet_out: assert property (s_paused ##1 !hold_n |-> $stable(miso_o))
      else $error("output moved while paused");
   chk_desel_floats: assert property (s_desel |-> miso_oe_n)
      else $error("output driven while deselected");
   // Shift lags the clock fall by the synchroniser, so look two cycles back
   chk_miso_after_fall: assert property ($changed(miso_o) && !cs_n |-> !$past(sck, 2))
      else $error("output shifted outside clock low");
   // Master side
   chk_idle_hold_high: assert property (cs_n |-> hold_n)
      else $error("pause low while deselected");
   chk_select_kept: assert property (!hold_n |=> !cs_n)
      else $error("select dropped during pause");
   chk_pause_enter_low: assert property ($fell(hold_n) |-> !sck)
      else $error("pause entered with clock high");
   chk_resume_low: assert property ($rose(hold_n) |-> !sck)
      else $error("pause released with clock high");
   chk_mosi_on_fall: assert property ($changed(mosi) && !cs_n && !$fell(cs_n) |-> $fell(sck))
      else $error("data in changed off a clock fall");
endmodule // pause_link_monitor

// [testbench/tb.sv]
// Self-checking bench: master and device ends joined face to face
`timescale 1ns/1ps
module tb;
   import pause_link_pkg::*;
   logic clk, rst_n, sel, pause, m_valid, m_rdy, m_rxv, m_paused, rx_rdy, d_valid, d_rdy, d_rxv, d_paused, d_sel;
   logic [WORD_W-1:0] m_data, m_rx, d_data, d_rx;
   logic [WORD_W-1:0] dev_q[$];
   logic [WORD_W-1:0] mst_q[$];
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   pause_link_if link ();
   pause_master pause_master_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .link(link), .i_select(sel), .i_pause(pause),
      .i_tx_data(m_data), .i_tx_valid(m_valid), .o_tx_ready(m_rdy), .o_rx_data(m_rx), .o_rx_valid(m_rxv),
      .o_paused(m_paused));
   pause_device pause_device_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .link(link), .o_rx_data(d_rx),
      .o_rx_valid(d_rxv), .i_rx_ready(rx_rdy), .i_tx_data(d_data), .i_tx_valid(d_valid), .o_tx_ready(d_rdy),
      .o_paused(d_paused), .o_selected(d_sel));
   pause_link_monitor pause_link_monitor_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .sck(link.sck),
      .cs_n(link.cs_n), .hold_n(link.hold_n), .mosi(link.mosi), .miso_o(link.miso_o),
      .miso_oe_n(link.miso_oe_n), .miso(link.miso));
   // Clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Collect words at both ends; a hang ends the run
   always @(posedge clk) begin
      if (d_rxv === 1'b1 && rx_rdy === 1'b1) dev_q.push_back(d_rx);
      if (m_rxv === 1'b1) mst_q.push_back(m_rx);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Ready is a one-cycle pulse, so it is sampled at every falling edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (m_rdy !== 1'b1 && n < 400);
      check("tx taken", 8'h01, 8'(n < 400));
   endtask
   // One frame of two words; deselect only once the master has both back
   task automatic send2(input logic [7:0] a, input logic [7:0] b);
      dev_q.delete();
      mst_q.delete();
      @(negedge clk);
      sel = 1'b1;
      m_data = a;
      m_valid = 1'b1;
      wait_rdy();
      m_data = b;
      wait_rdy();
      m_valid = 1'b0;
      for (int n = 0; n < 400 && mst_q.size() < 2; n++) @(negedge clk);
      sel = 1'b0;
      for (int n = 0; n < 100 && link.cs_n !== 1'b1; n++) @(negedge clk);
      repeat (8) @(negedge clk);
   endtask
   task automatic verify(input logic [7:0] a, input logic [7:0] b, input logic [7:0] w);
      check("device word 0", a, dev_q[0]);
      check("device word 1", b, dev_q[1]);
      check("master word 1", w, mst_q[1]);
      check("deselected", 8'h00, 8'(d_sel));
      check("output floats", 8'h01, 8'(link.miso_oe_n));
      check("pause cleared", 8'h00, 8'(d_paused));
   endtask
   task automatic test_plain();
      d_data = 8'h3C;
      send2(8'hA5, 8'h5A);
      verify(8'hA5, 8'h5A, 8'h3C);
      $display("test_plain done");
   endtask
   // Pause in mid-word, hold it, then resume from the same bit
   task automatic test_pause();
      logic [7:0] nd;
      d_data = 8'h81;
      fork
         send2(8'hC3, 8'h96);
         begin
            repeat (30) @(negedge clk);
            pause = 1'b1;
            repeat (40) @(negedge clk);
            nd = 8'(dev_q.size());
            check("device paused", 8'h01, 8'(d_paused));
            check("master paused", 8'h01, 8'(m_paused));
            check("still selected", 8'h00, 8'(link.cs_n));
            check("output floats", 8'h01, 8'(link.miso_oe_n));
            check("wire idle", 8'h00, 8'(link.miso));
            repeat (40) @(negedge clk);
            check("no traffic", nd, 8'(dev_q.size()));
            pause = 1'b0;
         end
      join
      verify(8'hC3, 8'h96, 8'h81);
      $display("test_pause done");
   endtask
   // Receiver stalls for a whole frame; both words must wait in the buffer
   task automatic test_stall();
      rx_rdy = 1'b0;
      d_data = 8'hE7;
      send2(8'h01, 8'hFE);
      check("word waits", 8'h01, 8'(d_rxv));
      check("held word", 8'h01, d_rx);
      rx_rdy = 1'b1;
      repeat (8) @(negedge clk);
      verify(8'h01, 8'hFE, 8'hE7);
      $display("test_stall done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      sel = 1'b0;
      pause = 1'b0;
      m_valid = 1'b0;
      m_data = 8'h00;
      rx_rdy = 1'b1;
      d_valid = 1'b1;
      d_data = 8'h00;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      test_plain();
      test_pause();
      test_stall();
      summarize();
   end
endmodule // tb
